// >>> hdl/mpes_map.vh
// Event codes, unit-mask field position and increment limits for the event selector.
// Assumes the includer uses these as plain constants.
`ifndef MPES_MAP_VH
`define MPES_MAP_VH
`define MPES_UMASK_HI         15
`define MPES_UMASK_LO         8
`define MPES_EV_PRE_COUNT     8'h02
`define MPES_EV_RDBUF_ALLOC   8'h17
`define MPES_EV_RDBUF_BUSY    8'h18
`define MPES_EV_RDBUF_FULL    8'h19
`define MPES_EV_SELF_REFRESH  8'h43
`define MPES_EV_THROTTLE      8'h46
`define MPES_EV_CKE_ON        8'h47
`define MPES_EV_CHAN_PWRDN    8'h85
`define MPES_EV_CRIT_THROTTLE 8'h86
`define MPES_EV_RDQ_OCC       8'hE0
`define MPES_EV_RDQ_BUSY      8'hE1
`define MPES_EV_RDQ_FULL      8'hE2
`define MPES_EV_RDQ_ALLOC     8'hE3
`define MPES_EV_WRQ_OCC       8'hE4
`define MPES_EV_WRQ_BUSY      8'hE5
`define MPES_EV_WRQ_FULL      8'hE6
`define MPES_EV_WRQ_ALLOC     8'hE7
`define MPES_EV_WRQ_DRAIN     8'hE8
`define MPES_EV_WRQ_DRAIN_CYC 8'hE9
`define MPES_EV_CMD_A         8'hEA
`define MPES_EV_CMD_B         8'hEB
`define MPES_PWRDN_MAX_INC    3'h4
`define MPES_CTR_LAST         2'h3
`endif

// >>> hdl/mpes_mask_any.v
// Masked OR of a condition vector against a unit mask.
// Assumes both inputs are on the controller clock.
`timescale 1ns/100ps
module mpes_mask_any #(
   parameter WIDTH = 8
) (
   input  wire [WIDTH-1:0] i_cond,
   input  wire [WIDTH-1:0] i_mask,
   output wire             o_any
);
   // Union of selected sub-conditions, at most one per cycle
   assign o_any = |(i_cond & i_mask);
endmodule // mpes_mask_any

// >>> hdl/mpes_occ_track.v
// Occupancy tracker for one persistent-memory pending queue.
// Assumes allocations never exceed depth, since credits are held upstream.
`timescale 1ns/100ps
module mpes_occ_track #(
   parameter DEPTH = 32,
   parameter CW    = 6
) (
   input  wire          i_sys_clk,
   input  wire          i_rstn,
   input  wire          i_alloc,
   input  wire          i_release,
   output wire [CW-1:0] o_count,
   output wire          o_full,
   output wire          o_busy
);
   reg [CW-1:0] count_reg;
   reg [CW-1:0] count_next;
   always @* begin
      count_next = count_reg;
      // Release only after data moved; simultaneous pair leaves count unchanged
      if (i_alloc && !i_release) begin
         count_next = count_reg + {{(CW-1){1'b0}}, 1'b1};
      end else if (!i_alloc && i_release && count_reg != {CW{1'b0}}) begin
         count_next = count_reg - {{(CW-1){1'b0}}, 1'b1};
      end
   end
   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         count_reg <= {CW{1'b0}};
      end else begin
         count_reg <= count_next;
      end
   end
   assign o_count = count_reg;
   assign o_full  = (count_reg == DEPTH[CW-1:0]);
   assign o_busy  = (count_reg != {CW{1'b0}});
endmodule // mpes_occ_track

// >>> hdl/mpes_event_select.v
// Event selection and per-cycle increment for one memory-controller monitoring counter.
// Assumes all condition inputs come from controller logic on i_sys_clk; counter lives outside.
// Function
// - Command event A bits 0-2: all, reads, writes
// - Command event A bits 3-7: underfill, grants, misc
// - Command event B bits 0-2: opportunistic, empty packets
// - Command event B bits 3-7: slots, faults, starvation
// - Count read queue allocations, all request classes
// - Read occupancy summed per cycle, three entry kinds
// - Read entry held until data transferred
// - Write allocations and occupancy by three kinds
// - Write entry freed after data reached module
// - Read queue full and busy cycle events
// - Write queue full, busy and drain events
// - All ranks powered down, up to four
// - Clock-enable-on for one-hot rank, one max
// - Throttle events by slot, causes not separated
// - Several throttled slots still add exactly one
// - Self-refresh counted only while clock runs
// - Precharge by read, write, page-table cause
// - Read buffer full, allocs, busy; one each
// - Unit mask from event select bits 15:8
`timescale 1ns/100ps
`include "mpes_map.vh"
module mpes_event_select #(
   parameter RDQ_DEPTH = 32,
   parameter WRQ_DEPTH = 32,
   parameter OCW       = 6,
   parameter INCW      = 8
) (
   input  wire            i_sys_clk,
   input  wire            i_rstn,
   input  wire [15:0]     i_event_select,
   input  wire [1:0]      i_counter_index,
   input  wire [7:0]      i_pmem_command_event_a,
   input  wire [7:0]      i_pmem_command_event_b,
   input  wire            i_pmem_read_q_alloc,
   input  wire            i_pmem_read_q_release,
   input  wire [OCW-1:0]  i_read_q_no_grant_count,
   input  wire [OCW-1:0]  i_read_q_grant_wait_count,
   input  wire            i_pmem_write_q_alloc,
   input  wire            i_pmem_write_q_release,
   input  wire [OCW-1:0]  i_write_q_cas_count,
   input  wire [OCW-1:0]  i_write_q_power_count,
   input  wire            i_pmem_write_q_drain,
   input  wire            i_pmem_write_q_drain_active,
   input  wire [3:0]      i_rank_precharge_powerdown,
   input  wire [7:0]      i_rank_cke_on,
   input  wire [1:0]      i_slot_throttled,
   input  wire [1:0]      i_slot_crit_throttled,
   input  wire            i_self_refresh,
   input  wire [7:0]      i_precharge_cause,
   input  wire            i_read_buf_full,
   input  wire            i_read_buf_alloc,
   input  wire            i_read_buf_busy,
   output reg  [INCW-1:0] o_increment,
   output reg             o_event_known,
   output reg             o_read_q_full,
   output reg             o_write_q_full
);
   // Selector fields
   wire [7:0] event_code = i_event_select[7:0];
   wire [7:0] unit_mask  = i_event_select[`MPES_UMASK_HI:`MPES_UMASK_LO];

   wire [OCW-1:0] rdq_count;
   wire           rdq_full;
   wire           rdq_busy;
   wire [OCW-1:0] wrq_count;
   wire           wrq_full;
   wire           wrq_busy;

   // Credits upstream keep allocations within depth, so no overflow guard is needed
   mpes_occ_track #(.DEPTH(RDQ_DEPTH), .CW(OCW)) u_rdq (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_alloc   (i_pmem_read_q_alloc),
      .i_release (i_pmem_read_q_release),
      .o_count   (rdq_count),
      .o_full    (rdq_full),
      .o_busy    (rdq_busy)
   );

   mpes_occ_track #(.DEPTH(WRQ_DEPTH), .CW(OCW)) u_wrq (
      .i_sys_clk (i_sys_clk),
      .i_rstn    (i_rstn),
      .i_alloc   (i_pmem_write_q_alloc),
      .i_release (i_pmem_write_q_release),
      .o_count   (wrq_count),
      .o_full    (wrq_full),
      .o_busy    (wrq_busy)
   );

   wire cmd_a_hit;
   wire cmd_b_hit;
   wire cke_hit;
   wire thr_hit;
   wire crit_hit;
   wire pre_hit;

   mpes_mask_any #(.WIDTH(8)) u_cmd_a (
      .i_cond (i_pmem_command_event_a),
      .i_mask (unit_mask),
      .o_any  (cmd_a_hit)
   );

   mpes_mask_any #(.WIDTH(8)) u_cmd_b (
      .i_cond (i_pmem_command_event_b),
      .i_mask (unit_mask),
      .o_any  (cmd_b_hit)
   );

   // Several ranks on at once still add one
   mpes_mask_any #(.WIDTH(8)) u_cke (
      .i_cond (i_rank_cke_on),
      .i_mask (unit_mask),
      .o_any  (cke_hit)
   );

   mpes_mask_any #(.WIDTH(2)) u_thr (
      .i_cond (i_slot_throttled),
      .i_mask (unit_mask[1:0]),
      .o_any  (thr_hit)
   );

   mpes_mask_any #(.WIDTH(2)) u_crit (
      .i_cond (i_slot_crit_throttled),
      .i_mask (unit_mask[1:0]),
      .o_any  (crit_hit)
   );

   // Bits 2 and 3 together give page misses; b00011100 gives all causes
   mpes_mask_any #(.WIDTH(8)) u_pre (
      .i_cond (i_precharge_cause),
      .i_mask (unit_mask),
      .o_any  (pre_hit)
   );

   // Occupancy with several mask bits: lowest selected mask bit wins, to stay within one queue
   reg [OCW-1:0] rdq_occ;
   reg [OCW-1:0] wrq_occ;
   always @* begin
      rdq_occ = {OCW{1'b0}};
      if (unit_mask[0]) begin
         rdq_occ = rdq_count;
      end else if (unit_mask[1]) begin
         rdq_occ = i_read_q_no_grant_count;
      end else if (unit_mask[2]) begin
         rdq_occ = i_read_q_grant_wait_count;
      end
   end
   always @* begin
      wrq_occ = {OCW{1'b0}};
      if (unit_mask[0]) begin
         wrq_occ = wrq_count;
      end else if (unit_mask[1]) begin
         wrq_occ = i_write_q_cas_count;
      end else if (unit_mask[2]) begin
         wrq_occ = i_write_q_power_count;
      end
   end

   wire [2:0] pwrdn_inc = (&i_rank_precharge_powerdown) ? `MPES_PWRDN_MAX_INC : 3'h0;
   wire       rdb_ok    = (i_counter_index <= `MPES_CTR_LAST);

   reg [INCW-1:0] inc_next;
   reg            known_next;
   always @* begin
      inc_next   = {INCW{1'b0}};
      known_next = 1'b1;
      case (event_code)
         `MPES_EV_CMD_A:         inc_next = {{(INCW-1){1'b0}}, cmd_a_hit};
         `MPES_EV_CMD_B:         inc_next = {{(INCW-1){1'b0}}, cmd_b_hit};
         `MPES_EV_RDQ_ALLOC:     inc_next = {{(INCW-1){1'b0}}, i_pmem_read_q_alloc};
         `MPES_EV_RDQ_OCC:       inc_next = {{(INCW-OCW){1'b0}}, rdq_occ};
         `MPES_EV_RDQ_FULL:      inc_next = {{(INCW-1){1'b0}}, rdq_full};
         `MPES_EV_RDQ_BUSY:      inc_next = {{(INCW-1){1'b0}}, rdq_busy};
         `MPES_EV_WRQ_ALLOC:     inc_next = {{(INCW-1){1'b0}}, i_pmem_write_q_alloc};
         `MPES_EV_WRQ_OCC:       inc_next = {{(INCW-OCW){1'b0}}, wrq_occ};
         `MPES_EV_WRQ_FULL:      inc_next = {{(INCW-1){1'b0}}, wrq_full};
         `MPES_EV_WRQ_BUSY:      inc_next = {{(INCW-1){1'b0}}, wrq_busy};
         `MPES_EV_WRQ_DRAIN:     inc_next = {{(INCW-1){1'b0}}, i_pmem_write_q_drain};
         `MPES_EV_WRQ_DRAIN_CYC: inc_next = {{(INCW-1){1'b0}}, i_pmem_write_q_drain_active};
         `MPES_EV_CHAN_PWRDN:    inc_next = {{(INCW-3){1'b0}}, pwrdn_inc};
         `MPES_EV_CKE_ON:        inc_next = {{(INCW-1){1'b0}}, cke_hit};
         `MPES_EV_THROTTLE:      inc_next = {{(INCW-1){1'b0}}, thr_hit};
         `MPES_EV_CRIT_THROTTLE: inc_next = {{(INCW-1){1'b0}}, crit_hit};
         // Stopped controller clock means no edges, so those periods are lost
         `MPES_EV_SELF_REFRESH:  inc_next = {{(INCW-1){1'b0}}, i_self_refresh};
         `MPES_EV_PRE_COUNT:     inc_next = {{(INCW-1){1'b0}}, pre_hit};
         `MPES_EV_RDBUF_FULL:    inc_next = {{(INCW-1){1'b0}}, i_read_buf_full & rdb_ok};
         `MPES_EV_RDBUF_ALLOC:   inc_next = {{(INCW-1){1'b0}}, i_read_buf_alloc & rdb_ok};
         `MPES_EV_RDBUF_BUSY:    inc_next = {{(INCW-1){1'b0}}, i_read_buf_busy & rdb_ok};
         default:                known_next = 1'b0;
      endcase
   end

   // Registered so every output is a flop; adds one cycle of latency
   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_increment    <= {INCW{1'b0}};
         o_event_known  <= 1'b0;
         o_read_q_full  <= 1'b0;
         o_write_q_full <= 1'b0;
      end else begin
         o_increment    <= inc_next;
         o_event_known  <= known_next;
         o_read_q_full  <= rdq_full;
         o_write_q_full <= wrq_full;
      end
   end
   // Invert and edge detect live in the counter outside; misuse there is software's
endmodule // mpes_event_select

// >>> testbench/mpes_event_checker.sv
// Checker: increment relations of the event selector.
// Assumes default widths; bound to the selector below.
`timescale 1ns/100ps
module mpes_event_checker (
   input wire        i_sys_clk,
   input wire        i_rstn,
   input wire [15:0] i_event_select,
   input wire [7:0]  i_pmem_command_event_a,
   input wire [7:0]  i_pmem_command_event_b,
   input wire [3:0]  i_rank_precharge_powerdown,
   input wire [7:0]  i_rank_cke_on,
   input wire [1:0]  i_slot_throttled,
   input wire        i_self_refresh,
   input wire [7:0]  i_precharge_cause,
   input wire [7:0]  o_increment
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);
   wire [7:0] ev = i_event_select[7:0];
   wire [7:0] um = i_event_select[15:8];
   sequence s_self_ref;
      ev == 8'h43 && i_self_refresh;
   endsequence
   sequence s_pwrdn_all;
      ev == 8'h85 && (&i_rank_precharge_powerdown);
   endsequence
   // Plain boolean, so free simulators need no sequence methods
   sequence s_pwrdn_part;
      ev == 8'h85 && !(&i_rank_precharge_powerdown);
   endsequence
   chk_self_ref: assert property (s_self_ref |=> o_increment == 8'h01)
      else $error("self refresh not counted");
   chk_pwrdn_four: assert property (s_pwrdn_all |=> o_increment == 8'h04)
      else $error("power down not four");
   chk_pwrdn_part: assert property (s_pwrdn_part |=> o_increment == 8'h00)
      else $error("partial power down counted");
   chk_cmd_a: assert property (ev == 8'hEA |=>
      o_increment == {7'h00, $past(|(um & i_pmem_command_event_a))}) else $error("command a");
   chk_cmd_b: assert property (ev == 8'hEB |=>
      o_increment == {7'h00, $past(|(um & i_pmem_command_event_b))}) else $error("command b");
   chk_throttle_one: assert property (ev == 8'h46 |=>
      o_increment == {7'h00, $past(|(um[1:0] & i_slot_throttled))}) else $error("throttle");
   chk_cke_rank: assert property (ev == 8'h47 |=>
      o_increment == {7'h00, $past(|(um & i_rank_cke_on))}) else $error("clock enable");
   chk_precharge_cause: assert property (ev == 8'h02 |=>
      o_increment == {7'h00, $past(|(um & i_precharge_cause))}) else $error("precharge");
endmodule // mpes_event_checker
bind mpes_event_select mpes_event_checker i_mpes_event_checker (.i_sys_clk(i_sys_clk),
   .i_rstn(i_rstn), .i_event_select(i_event_select),
   .i_pmem_command_event_a(i_pmem_command_event_a),
   .i_pmem_command_event_b(i_pmem_command_event_b),
   .i_rank_precharge_powerdown(i_rank_precharge_powerdown), .i_rank_cke_on(i_rank_cke_on),
   .i_slot_throttled(i_slot_throttled), .i_self_refresh(i_self_refresh),
   .i_precharge_cause(i_precharge_cause), .o_increment(o_increment));

// >>> testbench/mpes_queue_agent.sv
// Requester model: holds queue credits, pulses alloc and release.
// Assumes wants change at the falling edge.
`timescale 1ns/100ps
module mpes_queue_agent #(
   parameter DEPTH = 4
) (
   input  wire i_sys_clk,
   input  wire i_rstn,
   input  wire i_want_alloc,
   input  wire i_want_release,
   output wire o_alloc,
   output wire o_release
);
   reg [7:0] held_reg;
   // Sends only with a credit in hand
   assign o_alloc = i_want_alloc && (held_reg < DEPTH);
   // Only outstanding entries come back
   assign o_release = i_want_release && (held_reg != 8'h00);
   always @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn)
         held_reg <= 8'h00;
      else
         held_reg <= held_reg + o_alloc - o_release;
   end
endmodule // mpes_queue_agent

// >>> testbench/test_memctl_perf_event_select.sv
// Bench for the event selector with queue requester models.
// Assumes queue depth 4 on both queues.
`timescale 1ns/100ps
module test_memctl_perf_event_select;
   localparam [47:0] FLAGS = 48'hE8E917181943;
   reg        clk, rstn, drain, drn_on, sref, rb_f, rb_a, rb_b, rw_a, rw_r, ww_a, ww_r;
   reg [15:0] sel;
   reg [7:0]  cmd_a, cmd_b, cke, pre;
   reg [5:0]  cnt_a, cnt_b;
   reg [3:0]  pwrdn;
   reg [1:0]  thr, cthr;
   wire [7:0] inc;
   wire       known, rq_full, wq_full, rd_a, rd_r, wr_a, wr_r;
   integer    fail_count, checks_done, i;
   mpes_event_select #(.RDQ_DEPTH(4), .WRQ_DEPTH(4)) i_mpes_event_select (
      .i_sys_clk(clk), .i_rstn(rstn), .i_event_select(sel), .i_counter_index(2'h0),
      .i_pmem_command_event_a(cmd_a), .i_pmem_command_event_b(cmd_b),
      .i_pmem_read_q_alloc(rd_a), .i_pmem_read_q_release(rd_r),
      .i_read_q_no_grant_count(cnt_a), .i_read_q_grant_wait_count(cnt_b),
      .i_pmem_write_q_alloc(wr_a), .i_pmem_write_q_release(wr_r),
      .i_write_q_cas_count(cnt_a), .i_write_q_power_count(cnt_b),
      .i_pmem_write_q_drain(drain), .i_pmem_write_q_drain_active(drn_on),
      .i_rank_precharge_powerdown(pwrdn), .i_rank_cke_on(cke), .i_slot_throttled(thr),
      .i_slot_crit_throttled(cthr), .i_self_refresh(sref), .i_precharge_cause(pre),
      .i_read_buf_full(rb_f), .i_read_buf_alloc(rb_a), .i_read_buf_busy(rb_b),
      .o_increment(inc), .o_event_known(known), .o_read_q_full(rq_full),
      .o_write_q_full(wq_full));
   mpes_queue_agent #(.DEPTH(4)) i_mpes_queue_agent (.i_sys_clk(clk), .i_rstn(rstn),
      .i_want_alloc(rw_a), .i_want_release(rw_r), .o_alloc(rd_a), .o_release(rd_r));
   mpes_queue_agent #(.DEPTH(4)) i_mpes_queue_agent_wr (.i_sys_clk(clk), .i_rstn(rstn),
      .i_want_alloc(ww_a), .i_want_release(ww_r), .o_alloc(wr_a), .o_release(wr_r));
   task check(input string nm, input [7:0] seen, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
         end
      end
   endtask
   // Called at a falling edge; one rising edge registers the increment
   task run(input [15:0] s, input [7:0] exp);
      begin
         sel = s;
         @(negedge clk);
         check("increment", inc, exp);
      end
   endtask
   task t_cmd;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            cmd_a = 8'h01 << i;
            cmd_b = ~cmd_a;
            run({cmd_a, 8'hEA}, 8'h01);
            run({cmd_a, 8'hEB}, 8'h00);
            cmd_b = cmd_a;
            run({cmd_a, 8'hEB}, 8'h01);
         end
         cmd_a = 8'h81;
         run(16'hFFEA, 8'h01);
      end
   endtask
   task t_power;
      begin
         pwrdn = 4'hF;
         run(16'h0085, 8'h04);
         pwrdn = 4'h7;
         run(16'h0085, 8'h00);
         // Raw levels only; invert and edge detect stay off, never combined
         for (i = 0; i < 4; i = i + 1) begin
            cke = 8'h0F;
            run({8'h01 << i, 8'h47}, 8'h01);
            cke = 8'h0F ^ (8'h01 << i);
            run({8'h01 << i, 8'h47}, 8'h00);
            // Only the three defined causes; the fourth pass repeats the read cause
            pre = 8'h04 << (i % 3);
            run({pre, 8'h02}, 8'h01);
            run({8'h1C ^ pre, 8'h02}, 8'h00);
         end
         pre = 8'h0C;
         run(16'h0C02, 8'h01);
         {thr, cthr} = 4'hF;
         run(16'h0346, 8'h01);
         run(16'h0386, 8'h01);
         {thr, cthr} = 4'h6;
         run(16'h0246, 8'h00);
         run(16'h0186, 8'h00);
      end
   endtask
   task t_flags;
      begin
         {drain, drn_on, sref, rb_f, rb_a, rb_b} = 6'h3F;
         for (i = 0; i < 6; i = i + 1)
            run({8'h00, FLAGS[8*i +: 8]}, 8'h01);
         check("known", {7'h00, known}, 8'h01);
         {drain, drn_on, sref, rb_f, rb_a, rb_b} = 6'h00;
         for (i = 0; i < 6; i = i + 1)
            run({8'h00, FLAGS[8*i +: 8]}, 8'h00);
         run(16'h0044, 8'h00);
         check("known", {7'h00, known}, 8'h00);
      end
   endtask
   // Request past depth (credits stop at four), read all views, drain, then one fresh alloc
   task t_queue(input [7:0] b, input wr);
      begin
         {cnt_a, cnt_b} = 12'h0C2;
         {ww_a, rw_a} = {wr, !wr};
         repeat (6) @(negedge clk);
         {ww_a, rw_a} = 2'h0;
         run({8'h01, b}, 8'h04);
         run({8'h02, b}, 8'h03);
         run({8'h04, b}, 8'h02);
         run({8'h00, b + 8'h01}, 8'h01);
         run({8'h00, b + 8'h02}, 8'h01);
         check("full", {7'h00, wr ? wq_full : rq_full}, 8'h01);
         run({8'h00, b + 8'h03}, 8'h00);
         {ww_r, rw_r} = {wr, !wr};
         repeat (6) @(negedge clk);
         {ww_r, rw_r} = 2'h0;
         run({8'h00, b + 8'h01}, 8'h00);
         check("full", {7'h00, wr ? wq_full : rq_full}, 8'h00);
         {ww_a, rw_a} = {wr, !wr};
         run({8'h00, b + 8'h03}, 8'h01);
         {ww_a, rw_a} = 2'h0;
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", checks_done, fail_count);
         if (fail_count == 0 && checks_done > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard
   initial begin
      repeat (5000) @(posedge clk);
      fail_count = fail_count + 1;
      tally_and_finish;
   end
   initial begin
      fail_count = 0;
      checks_done = 0;
      rstn = 1'b0;
      sel = 16'h0000;
      {cmd_a, cmd_b, cke, pre, cnt_a, cnt_b, pwrdn, thr, cthr} = '0;
      {drain, drn_on, sref, rb_f, rb_a, rb_b, rw_a, rw_r, ww_a, ww_r} = '0;
      repeat (3) @(posedge clk);
      @(negedge clk) rstn = 1'b1;
      @(negedge clk);
      t_cmd;
      t_power;
      t_flags;
      t_queue(8'hE0, 1'b0);
      t_queue(8'hE4, 1'b1);
      tally_and_finish;
   end
endmodule // test_memctl_perf_event_select
